// ---- src/hbsc_pkg.sv ----
package hbsc_pkg;
    // Clock rate and derived cycle counts
    localparam int CLK_MHZ      = 200;
    localparam int SS_TIME_US   = 1500;
    localparam int SS_CYC       = SS_TIME_US * CLK_MHZ;
    localparam int REST_TIME_MS = 100;
    localparam int REST_CYC     = REST_TIME_MS * 1000 * CLK_MHZ;
    localparam int SLOW_TIME_US = 2100;
    localparam int SLOW_CYC     = SLOW_TIME_US * CLK_MHZ;
    localparam int FILT_NS      = 150;
    localparam int SYNC_W_NS    = 150;
    localparam int FAST_NS      = 100;
    localparam int SLOW_NS      = 100;
    localparam int DT_BASE_NS   = 150;
    localparam int DT_MIN_NS    = 50;
    localparam int DEADTIME_CEILING_NS    = 1350;
    localparam int HP_W         = 18;
    localparam int MV_W         = 13;
    localparam logic [5:0] FILT_CYC = 6'(FILT_NS * CLK_MHZ / 1000);
    localparam logic [HP_W-1:0] SYNC_W_CYC =
        HP_W'((SYNC_W_NS * CLK_MHZ + 999) / 1000);
    localparam logic [5:0] FAST_CYC = 6'((FAST_NS * CLK_MHZ + 999) / 1000);
    localparam logic [5:0] SLOW_MIN_CYC =
        6'((SLOW_NS * CLK_MHZ + 999) / 1000);
    // Dead-time numerator in cycles times millivolts (1 V = 1000 mV)
    localparam int DT_NUM = DT_BASE_NS * CLK_MHZ;
    localparam logic [9:0] DT_MIN_CYC =
        10'((DT_MIN_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] DEADTIME_CEILING_CYC = 10'(DEADTIME_CEILING_NS * CLK_MHZ / 1000);
    // Limit/dead-time pin voltage thresholds in mV
    localparam logic [MV_W-1:0] MV_OFS   = 13'h0384;
    localparam logic [MV_W-1:0] MV_SHORT = 13'h01F4;
    localparam logic [MV_W-1:0] MV_RANGE = 13'h0F6E;
    localparam logic [MV_W-1:0] MV_OPEN  = 13'h1194;
    // Soft-start extra half period: 3/2 of the set value at start
    localparam int SS_EXTRA_NUM = 3;
    // Up and down weights give 2.1 ms up versus 180 ms down
    localparam logic [21:0] UP_W = 22'h000258;
    localparam logic [21:0] DN_W = 22'h000007;
    // Sync range in percent of the programmed frequency
    localparam logic [7:0] SYNC_LO_PCT = 8'h73;
    localparam logic [7:0] SYNC_HI_PCT = 8'h82;
    localparam logic [7:0] PCT         = 8'h64;

    typedef struct packed {
        logic sync_ref;
        logic disable_in;
        logic near_hi_rail;
        logic near_lo_rail;
        logic slow_oc_ls;
        logic fast_oc_hs;
        logic fast_oc_ls;
    } hbsc_sense_t;

    typedef struct packed {
        logic hs;
        logic ls;
    } hbsc_gate_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_HS    = 3'h1,
        ST_DT_LS = 3'h2,
        ST_LS    = 3'h3,
        ST_DT_HS = 3'h4,
        ST_FAULT = 3'h5
    } hbsc_state_t;

    typedef enum logic [1:0] {
        SY_OFF   = 2'h0,
        SY_CHECK = 2'h1,
        SY_SEEK  = 2'h2,
        SY_LOCK  = 2'h3
    } hbsc_sync_t;

    typedef enum logic [2:0] {
        FC_NONE     = 3'h0,
        FC_DT_SHORT = 3'h1,
        FC_DT_RANGE = 3'h2,
        FC_DT_OPEN  = 3'h3,
        FC_SLOW_OC  = 3'h4,
        FC_FAST_OC  = 3'h5
    } hbsc_fault_t;
endpackage : hbsc_pkg

// ---- src/hbsc_switch_ctrl.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Sync ignored during soft-start; internal oscillator only.
// - After soft-start, follow sync only when present and in range.
// - Check sync frequency, then seek transition point, then lock.
// - Once locked, the upper frequency limit is no longer checked.
// - Watchdog drops lock when sync falls below the set frequency.
// - Locked: gate state toggles on every sync rising edge.
// - Switching edge lags the sync edge by a filter delay.
// - Dead-time ends when switch node reaches the opposite rail.
// - Without rail detection the switch turns on at dead-time ceiling.
// - Ceiling is 150 ns times 1 V over pin voltage minus 0.9 V.
// - Effective ceiling is the smaller of pin value and period/8.
// - Pin-programmed ceiling clamped between 50 ns and 1.35 us.
// - Pin short, out-of-range and open faults shut switching down.
// - Slow overcurrent: low-side on-time current, trips after 2.1 ms.
// - Fast overcurrent trips on either switch after 100 ns excess.
// - During soft-start slow detection off, fast threshold at maximum.
// - After soft-start slow detection on, fast threshold five times it.
// - Up-down counter: up on cycles over 100 ns, else down.
// - Counter scaled: 2.1 ms up to trip, 180 ms back down.
// - After a trip wait the restart time before switching again.
// - Any fault stops switching, pulls fault pin low, shows code.
// - Soft-start sweeps period linearly from 2.5x down to set value.
// - First pulse is high side, half the next width; then 50 percent.
module hbsc_switch_ctrl
    import hbsc_pkg::*;
#(
    parameter int SS_CYCLES   = SS_CYC,
    parameter int REST_CYCLES = REST_CYC,
    parameter int SLOW_CYCLES = SLOW_CYC
) (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            resetn,
    // Comparators and pins, asynchronous
    input  wire hbsc_sense_t     sense_async,
    // Digitised pin settings, same clock
    input  wire logic [15:0]     freq_set_half,
    input  wire logic [MV_W-1:0] limit_deadtime_mv,
    // Gate drive and fault pin
    output hbsc_gate_t           gate,
    output logic                 disable_fault_oe,
    output logic                 disable_fault_out,
    output hbsc_fault_t          fault_code,
    // Status
    output logic                 fast_thr_max,
    output logic                 slow_ocp_en,
    output logic                 sync_locked,
    output logic [9:0]           deadtime_ceiling
);
    localparam logic [39:0] TRIP = 40'(SLOW_CYCLES) * 40'(UP_W);

    hbsc_sense_t     s1, s;
    hbsc_state_t     state, next_state;
    hbsc_sync_t      sy, next_sy;
    hbsc_fault_t     next_fault_code;
    logic [31:0]     ss_cnt, next_ss_cnt, rest_cnt, next_rest_cnt;
    logic            ss_act, next_ss_act, first, next_first;
    logic            sp, next_sp, hi_ok, next_hi_ok, good, next_good;
    logic            filt_run, next_filt_run, slow_hit, next_slow_hit;
    logic [HP_W-1:0] on_cnt, next_on_cnt, half_cur, next_half_cur;
    logic [HP_W-1:0] per_cnt, next_per_cnt, w_cnt, next_w_cnt;
    logic [HP_W-1:0] sync_per, next_sync_per, cyc_len, next_cyc_len;
    logic [9:0]      dt_cnt, next_dt_cnt;
    logic [5:0]      filt_cnt, next_filt_cnt;
    logic [5:0]      slow_run, next_slow_run, fast_run, next_fast_run;
    logic [39:0]     acc, next_acc, step_up, step_dn;
    logic            rise, fall, running, on_phase, range_ok, tog;
    logic            fault_now, fast_hi;
    logic [HP_W-1:0] pp, on_len, ramp;
    logic [49:0]     ramp_prod;
    logic [MV_W-1:0] mv_d;
    logic [15:0]     dt_raw;
    logic [9:0]      dt_pin, dt_per, dt_lim;
    logic [31:0]     rng_set, rng_lo, rng_hi;

    // Pins pass two flops before any logic looks at them
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1 <= '0;
            s  <= '0;
        end
        else
        begin
            s1 <= sense_async;
            s  <= s1;
        end
    end

    assign rise     = s.sync_ref & ~sp;
    assign fall     = ~s.sync_ref & sp;
    assign running  = (state != ST_IDLE) && (state != ST_FAULT);
    assign on_phase = (state == ST_HS) || (state == ST_LS);
    assign pp       = per_cnt + HP_W'(1);
    assign rng_set  = 32'(freq_set_half) * 32'(PCT);
    assign rng_lo   = 32'(pp) * 32'(SYNC_LO_PCT);
    assign rng_hi   = 32'(pp) * 32'(SYNC_HI_PCT);
    assign range_ok = (rng_lo < rng_set) && (rng_set < rng_hi);
    assign on_len   = first ? (half_cur >> 1) : half_cur;
    assign tog      = filt_run && (filt_cnt == FILT_CYC - 6'h01);
    assign ramp_prod = 50'(freq_set_half) * 50'(SS_EXTRA_NUM)
                     * 50'(32'(SS_CYCLES) - ss_cnt);
    assign ramp = HP_W'(freq_set_half)
                + HP_W'(ramp_prod / 50'(2 * SS_CYCLES));
    assign mv_d   = limit_deadtime_mv - MV_OFS;
    assign dt_raw = 16'(DT_NUM / ((mv_d == '0) ? 1 : int'(mv_d)));
    // clamp to 50 ns .. 1.35 us
    assign dt_pin = (limit_deadtime_mv <= MV_OFS || dt_raw > 16'(DEADTIME_CEILING_CYC))
                  ? DEADTIME_CEILING_CYC
                  : (dt_raw < 16'(DT_MIN_CYC)) ? DT_MIN_CYC : dt_raw[9:0];
    // also no more than an eighth of the period
    assign dt_per = (sy == SY_LOCK) ? 10'(sync_per >> 2) : 10'(half_cur >> 2);
    assign dt_lim = (dt_per == '0) ? 10'h001
                  : (dt_per < dt_pin) ? dt_per : dt_pin;
    assign fast_hi = s.fast_oc_hs | s.fast_oc_ls;
    assign step_up = 40'(cyc_len) * 40'(UP_W);
    assign step_dn = 40'(cyc_len) * 40'(DN_W);

    always_comb
    begin
        next_state = state;      next_sy = sy;
        next_ss_cnt = ss_cnt;    next_ss_act = ss_act;
        next_rest_cnt = rest_cnt; next_first = first;
        next_hi_ok = hi_ok;      next_good = good;
        next_filt_run = filt_run; next_filt_cnt = filt_cnt;
        next_on_cnt = on_cnt;    next_half_cur = half_cur;
        next_sync_per = sync_per; next_cyc_len = cyc_len;
        next_dt_cnt = dt_cnt;    next_acc = acc;
        next_slow_run = slow_run; next_slow_hit = slow_hit;
        next_fast_run = '0;      next_fault_code = fault_code;
        next_sp = s.sync_ref;    fault_now = 1'b0;
        // Sync pulse measurement, runs always
        next_w_cnt = (rise | fall) ? '0
                   : (w_cnt == '1) ? w_cnt : w_cnt + HP_W'(1);
        next_per_cnt = rise ? '0
                     : (per_cnt == '1) ? per_cnt : per_cnt + HP_W'(1);
        if (fall)
            next_hi_ok = w_cnt >= SYNC_W_CYC - HP_W'(1);
        if (rise)
        begin
            next_good = hi_ok && (w_cnt >= SYNC_W_CYC - HP_W'(1))
                      && range_ok;
            next_sync_per = pp;
        end
        // fixed filter delay after each sync rising edge that locks or arrives while locked
        if (filt_run)
        begin
            next_filt_cnt = filt_cnt + 6'h01;
            if (tog)
                next_filt_run = 1'b0;
        end
        case (sy)
            // sync stays off until soft-start is over
            SY_OFF:
                if (running && !ss_act)
                    next_sy = SY_CHECK;
            SY_CHECK:
                if (rise && next_good)
                    next_sy = SY_SEEK;
            // lock on an edge in the late half of an on-phase
            SY_SEEK:
                if (rise)
                begin
                    if (!next_good)
                        next_sy = SY_CHECK;
                    else if (on_phase && on_cnt >= (on_len >> 1))
                    begin
                        next_sy = SY_LOCK;
                        next_filt_run = 1'b1;
                        next_filt_cnt = '0;
                    end
                end
            // no upper check once locked; watchdog
            SY_LOCK:
                if (per_cnt >= {freq_set_half, 1'b0})
                    next_sy = SY_CHECK;
                else if (rise)
                begin
                    next_filt_run = 1'b1;
                    next_filt_cnt = '0;
                end
            default:
                next_sy = SY_OFF;
        endcase
        if (running)
            next_cyc_len = cyc_len + HP_W'(1);
        if (running && ss_act)
        begin
            next_ss_cnt = ss_cnt + 32'h1;
            if (ss_cnt >= 32'(SS_CYCLES - 1))
                next_ss_act = 1'b0;
        end
        case (state)
            ST_IDLE:
                if (s.disable_in)
                begin
                    next_state = ST_HS;
                    next_ss_cnt = '0;
                    next_ss_act = 1'b1;
                    next_first = 1'b1;
                    next_on_cnt = '0;
                    // Ramp start from a zero count; ss_cnt is stale here
                    next_half_cur = HP_W'(freq_set_half)
                        + HP_W'((32'(freq_set_half) * 32'(SS_EXTRA_NUM)) >> 1);
                    next_acc = '0;
                    next_cyc_len = '0;
                    next_fault_code = FC_NONE;
                end
            // locked: each filtered sync edge ends the phase
            ST_HS, ST_LS:
            begin
                next_on_cnt = on_cnt + HP_W'(1);
                if ((sy == SY_LOCK) ? tog
                    : (on_cnt >= on_len - HP_W'(1)))
                begin
                    next_state = (state == ST_HS) ? ST_DT_LS : ST_DT_HS;
                    next_dt_cnt = '0;
                    next_first = 1'b0;
                end
            end
            ST_DT_LS:
            begin
                next_dt_cnt = dt_cnt + 10'h001;
                if (s.near_lo_rail || dt_cnt >= dt_lim - 10'h001)
                begin
                    next_state = ST_LS;
                    next_on_cnt = '0;
                    next_half_cur = ss_act ? ramp : HP_W'(freq_set_half);
                    next_slow_run = '0;
                end
            end
            ST_DT_HS:
            begin
                next_dt_cnt = dt_cnt + 10'h001;
                if (s.near_hi_rail || dt_cnt >= dt_lim - 10'h001)
                begin
                    next_state = ST_HS;
                    next_on_cnt = '0;
                    next_half_cur = ss_act ? ramp : HP_W'(freq_set_half);
                    next_cyc_len = '0;
                    next_slow_hit = 1'b0;
                    // up or down once per switching cycle
                    // weights set the 2.1 ms / 180 ms rates
                    if (ss_act)
                        next_acc = '0;
                    else if (slow_hit)
                        next_acc = acc + step_up;
                    else
                        next_acc = (acc > step_dn) ? acc - step_dn : '0;
                end
            end
            ST_FAULT:
            begin
                next_rest_cnt = rest_cnt + 32'h1;
                if (rest_cnt >= 32'(REST_CYCLES - 1))
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
        if (state == ST_LS)
        begin
            next_slow_run = !s.slow_oc_ls ? '0
                : (slow_run == '1) ? slow_run : slow_run + 6'h01;
            if (s.slow_oc_ls && slow_run >= SLOW_MIN_CYC - 6'h01)
                next_slow_hit = 1'b1;
        end
        if (running)
        begin
            // fast trip after 100 ns, shorter pulses filtered
            next_fast_run = !fast_hi ? '0
                : (fast_run == '1) ? fast_run : fast_run + 6'h01;
            // pin faults, open checked before range
            if (limit_deadtime_mv < MV_SHORT)
                next_fault_code = FC_DT_SHORT;
            else if (limit_deadtime_mv > MV_OPEN)
                next_fault_code = FC_DT_OPEN;
            else if (limit_deadtime_mv >= MV_RANGE)
                next_fault_code = FC_DT_RANGE;
            else if (fast_hi && fast_run >= FAST_CYC - 6'h01)
                next_fault_code = FC_FAST_OC;
            else if (!ss_act && next_acc >= TRIP)
                next_fault_code = FC_SLOW_OC;
            fault_now = next_fault_code != FC_NONE;
            if (!s.disable_in)
                next_state = ST_IDLE;
            if (fault_now)
            begin
                next_state = ST_FAULT;
                next_rest_cnt = '0;
            end
        end
        if (next_state == ST_IDLE || next_state == ST_FAULT)
        begin
            next_sy = SY_OFF;
            next_filt_run = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= ST_IDLE;     sy <= SY_OFF;
            ss_cnt <= '0;         ss_act <= 1'b0;
            rest_cnt <= '0;       first <= 1'b0;
            sp <= 1'b0;           hi_ok <= 1'b0;
            good <= 1'b0;         filt_run <= 1'b0;
            filt_cnt <= '0;       on_cnt <= '0;
            half_cur <= '0;       per_cnt <= '0;
            w_cnt <= '0;          sync_per <= '0;
            cyc_len <= '0;        dt_cnt <= '0;
            acc <= '0;            slow_run <= '0;
            slow_hit <= 1'b0;     fast_run <= '0;
            gate <= '0;           disable_fault_oe <= 1'b0;
            disable_fault_out <= 1'b0;
            fault_code <= FC_NONE;
            fast_thr_max <= 1'b1; slow_ocp_en <= 1'b0;
            sync_locked <= 1'b0;  deadtime_ceiling <= '0;
        end
        else
        begin
            state <= next_state;  sy <= next_sy;
            ss_cnt <= next_ss_cnt; ss_act <= next_ss_act;
            rest_cnt <= next_rest_cnt; first <= next_first;
            sp <= next_sp;        hi_ok <= next_hi_ok;
            good <= next_good;    filt_run <= next_filt_run;
            filt_cnt <= next_filt_cnt; on_cnt <= next_on_cnt;
            half_cur <= next_half_cur; per_cnt <= next_per_cnt;
            w_cnt <= next_w_cnt;  sync_per <= next_sync_per;
            cyc_len <= next_cyc_len; dt_cnt <= next_dt_cnt;
            acc <= next_acc;      slow_run <= next_slow_run;
            slow_hit <= next_slow_hit; fast_run <= next_fast_run;
            gate.hs <= next_state == ST_HS;
            gate.ls <= next_state == ST_LS;
            disable_fault_oe <= next_state == ST_FAULT;
            disable_fault_out <= 1'b0;
            fault_code <= next_fault_code;
            // fast threshold five times the set level after
            fast_thr_max <= next_ss_act || next_state == ST_IDLE;
            slow_ocp_en <= !next_ss_act && next_state != ST_IDLE
                           && next_state != ST_FAULT;
            sync_locked <= next_sy == SY_LOCK;
            deadtime_ceiling <= dt_lim;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_rest_done;
        state == ST_FAULT && rest_cnt >= 32'(REST_CYCLES - 1);
    endsequence
    sequence s_restart;
        state == ST_IDLE ##1 (state == ST_HS && ss_act && first) [*1];
    endsequence

    AST_NO_OVERLAP: assert property (!(gate.hs && gate.ls))
        else $error("both gates on");
    AST_DEAD_GAP: assert property ($fell(gate.hs) |-> !gate.ls)
        else $error("no dead-time after high side");
    AST_SS_NO_SYNC: assert property (ss_act |-> sy == SY_OFF)
        else $error("sync active during soft-start");
    AST_FAULT_STOP: assert property (state == ST_FAULT |->
        !gate.hs && !gate.ls && disable_fault_oe && fault_code != FC_NONE)
        else $error("fault without stop and pull-down");
    AST_FAST_TRIP: assert property (running && fast_hi
        && fast_run == FAST_CYC - 6'h01 |=> state == ST_FAULT)
        else $error("fast overcurrent not tripped");
    AST_SS_THR: assert property (ss_act |-> fast_thr_max
        && !slow_ocp_en && acc == '0)
        else $error("soft-start thresholds wrong");
    AST_DT_EXPIRE: assert property (state == ST_DT_LS
        && dt_cnt == dt_lim - 10'h001 && !fault_now && s.disable_in
        |=> gate.ls)
        else $error("low side not on at ceiling");
    AST_WD: assert property (sy == SY_LOCK && running
        && per_cnt >= {freq_set_half, 1'b0} && !fault_now && s.disable_in
        |=> sy == SY_CHECK && !sync_locked)
        else $error("watchdog did not drop lock");
    AST_RESTART: assert property (s_rest_done |=>
        state == ST_IDLE && !disable_fault_oe)
        else $error("no restart after wait");
    AST_SS_RERUN: assert property (state == ST_IDLE && s.disable_in
        |-> s_restart)
        else $error("start without soft-start");
endmodule : hbsc_switch_ctrl

// ---- tb/hbsc_partner.sv ----
`timescale 1ns/1ps
module hbsc_partner
    import hbsc_pkg::*;
(
    // Clock and gate drives seen
    input  wire logic       sys_clk,
    input  wire hbsc_gate_t gate,
    // Scenario controls
    input  wire logic       sync_en,
    input  wire logic       stuck,
    // Senses
    output logic            sync_ref = 1'b0,
    output logic            near_hi_rail = 1'b0,
    output logic            near_lo_rail = 1'b0
);
    int   slew = 0;
    int   sync_cnt = 0;
    logic last_hs = 1'b0;
    // Stuck node: no tank current, so no rail is reached during dead-time
    always @(posedge sys_clk)
    begin
        if (gate.hs || gate.ls)
        begin
            last_hs      <= gate.hs;
            near_hi_rail <= gate.hs;
            near_lo_rail <= gate.ls;
            slew         <= 0;
        end
        else
        begin
            slew         <= slew + 1;
            near_hi_rail <= !stuck && !last_hs && slew >= 8;
            near_lo_rail <= !stuck && last_hs && slew >= 8;
        end
    end
    always @(posedge sys_clk)
    begin
        sync_cnt <= (!sync_en || sync_cnt == 164) ? 0 : sync_cnt + 1;
        if (!sync_en)
            sync_ref <= 1'b0;
        else if (sync_cnt == 164)
            sync_ref <= !sync_ref;
    end
endmodule : hbsc_partner

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
    import hbsc_pkg::*;
;
    logic            sys_clk = 1'b0;
    logic            resetn = 1'b0;
    logic            dis_in = 1'b0, slow_oc = 1'b0;
    logic            fast_hs = 1'b0, fast_ls = 1'b0;
    logic            sync_en = 1'b0, stuck = 1'b0;
    logic            sync_ref, near_hi, near_lo, oe, thr_max, ocp_en, locked;
    logic            fault_out;
    logic [MV_W-1:0] mv = 13'h05DC;
    hbsc_gate_t      gate;
    hbsc_fault_t     code;
    logic [9:0]      ceil_cyc;
    int              n_errors = 0, tests_run = 0, cyc = 0, i, n;
    always #2.5 sys_clk = ~sys_clk;
    hbsc_switch_ctrl #(.SS_CYCLES(2000), .REST_CYCLES(500),
        .SLOW_CYCLES(2000)) hbsc_switch_ctrl_inst (
        .sys_clk(sys_clk), .resetn(resetn),
        .sense_async(hbsc_sense_t'({sync_ref, dis_in, near_hi, near_lo,
            slow_oc, fast_hs, fast_ls})),
        .freq_set_half(16'h0190), .limit_deadtime_mv(mv), .gate(gate),
        .disable_fault_oe(oe), .disable_fault_out(fault_out),
        .fault_code(code),
        .fast_thr_max(thr_max), .slow_ocp_en(ocp_en), .sync_locked(locked),
        .deadtime_ceiling(ceil_cyc));
    hbsc_partner hbsc_partner_inst (.sys_clk(sys_clk), .gate(gate),
        .sync_en(sync_en), .stuck(stuck), .sync_ref(sync_ref),
        .near_hi_rail(near_hi), .near_lo_rail(near_lo));
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    task automatic dead_gap(output int g);
        @(negedge gate.hs);
        for (g = 0; g < 400 && gate.ls !== 1'b1; g++) @(posedge sys_clk);
    endtask : dead_gap
    task automatic wait_ss();
        for (i = 0; i < 2500 && ocp_en !== 1'b1; i++)
        begin
            check("no lock in soft-start", locked, 1'b0);
            @(posedge sys_clk);
        end
        check("slow on", ocp_en, 1'b1);
        check("fast scaled", thr_max, 1'b0);
    endtask : wait_ss
    task automatic t_fault(input hbsc_fault_t exp, input int bound);
        for (i = 0; i < bound && code !== exp; i++) @(posedge sys_clk);
        @(posedge sys_clk);
        check("fault code", code, exp);
        check("pin pulled", oe, 1'b1);
        check("pin low", fault_out, 1'b0);
        check("gates off", gate, 2'b00);
        mv <= 13'h05DC;
        fast_ls <= 1'b0;
        slow_oc <= 1'b0;
        for (n = 0; n < 600 && oe === 1'b1; n++) @(posedge sys_clk);
        check("restart wait", n >= 497 && n <= 502, 1'b1);
        for (i = 0; i < 10 && gate.hs !== 1'b1; i++) @(posedge sys_clk);
        check("restart high side", gate, 2'b10);
        check("restart fast max", thr_max, 1'b1);
        check("restart slow off", ocp_en, 1'b0);
        $display("test fault %0d done", exp);
    endtask : t_fault
    task automatic t_sync();
        realtime t0;
        hbsc_gate_t g;
        wait_ss();
        for (i = 0; i < 5000 && locked !== 1'b1; i++) @(posedge sys_clk);
        check("locked", locked, 1'b1);
        @(posedge sync_ref);
        g = gate;
        for (n = 0; n < 100 && gate === g; n++) @(posedge sys_clk);
        check("sync to edge", n >= 30 && n <= 36, 1'b1);
        @(posedge gate.hs);
        t0 = $realtime;
        @(posedge gate.hs);
        check("locked period", int'(($realtime - t0) / 5.0), 660);
        sync_en <= 1'b0;
        for (i = 0; i < 1200 && locked !== 1'b0; i++) @(posedge sys_clk);
        check("lock dropped", locked, 1'b0);
        $display("test sync done");
    endtask : t_sync
    task automatic t_dead();
        int g;
        repeat (20) @(posedge sys_clk);
        check("ceiling", ceil_cyc, 10'h032);
        mv <= 13'h044C;
        repeat (10) @(posedge sys_clk);
        check("period cap", ceil_cyc, 10'h064);
        mv <= 13'h0F64;
        repeat (10) @(posedge sys_clk);
        check("min clamp", ceil_cyc, 10'h00A);
        mv <= 13'h05DC;
        dead_gap(g);
        check("rail gap", g <= 15, 1'b1);
        stuck <= 1'b1;
        dead_gap(g);
        check("max gap", g >= 50 && g <= 53, 1'b1);
        stuck <= 1'b0;
        $display("test dead-time done");
    endtask : t_dead
    always @(posedge sys_clk)
        if (gate === 2'b11)
            check("gates overlap", 1'b1, 1'b0);
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            n_errors++;
            finish_test();
        end
    end
    initial
    begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        dis_in <= 1'b1;
        sync_en <= 1'b1;
        for (i = 0; i < 10 && gate !== 2'b10; i++) @(posedge sys_clk);
        check("first gate", gate, 2'b10);
        check("fast max", thr_max, 1'b1);
        check("slow off", ocp_en, 1'b0);
        for (n = 0; n < 900 && gate.hs === 1'b1; n++) @(posedge sys_clk);
        check("first width", n >= 499 && n <= 501, 1'b1);
        t_sync();
        t_dead();
        fast_hs <= 1'b1;
        repeat (10) @(posedge sys_clk);
        fast_hs <= 1'b0;
        repeat (30) @(posedge sys_clk);
        check("short pulse", code, FC_NONE);
        fast_ls <= 1'b1;
        t_fault(FC_FAST_OC, 60);
        mv <= 13'h0190;
        t_fault(FC_DT_SHORT, 60);
        mv <= 13'h0FA0;
        t_fault(FC_DT_RANGE, 60);
        mv <= 13'h11F8;
        t_fault(FC_DT_OPEN, 60);
        wait_ss();
        slow_oc <= 1'b1;
        t_fault(FC_SLOW_OC, 20000);
        finish_test();
    end
endmodule : tb_top
